// File: iaa_consts.vh
// Constants for the interrupt acknowledge and arbitration block.
// Assumes a single 50 MHz clock and a 2-bit Avalon-MM word address.
`ifndef IAA_CONSTS_VH
`define IAA_CONSTS_VH

// ==========================================================
// Register word indices
`define IAA_REG_CCR       2'h0
`define IAA_REG_ARB       2'h1
`define IAA_REG_STAT      2'h2
`define IAA_REG_PC        2'h3

// ==========================================================
// Field layout
`define IAA_MASK_HI       7
`define IAA_MASK_LO       5
`define IAA_BANK_HI       3
`define IAA_BANK_LO       0
`define IAA_ARB_W         4
`define IAA_LVL_W         3
`define IAA_VEC_W         8

// ==========================================================
// Reset values
`define IAA_MASK_RST      3'h7
`define IAA_BANK_RST      4'h0
`define IAA_ARB_SIM_RST   4'hF
`define IAA_ARB_MOD_RST   4'h0

// ==========================================================
// Acknowledge cycle encodings
`define IAA_FC_CPU        3'h7
`define IAA_ADDR_ONES     20'hFFFFF
`define IAA_ADDR_LSB      1'h1
`define IAA_LVL_NMI       3'h7
`define IAA_ARB_ZERO      4'h0
`define IAA_ARB_MSB       2'h3
`define IAA_SPUR_VEC      8'h18
`define IAA_AVEC_BASE     8'h18
`define IAA_VADDR_SHIFT   1

// ==========================================================
// Timing
`define IAA_CLK_NS        20
`define IAA_BMON_NS       1280
`define IAA_BMON_CYC      (`IAA_BMON_NS / `IAA_CLK_NS)

`endif

// File: iaa_req_qual.v
// Request qualifier: samples the seven request levels on falling edges.
// Assumes request levels are already merged, active high, clock-synchronous.
`timescale 1ns/1ps

module iaa_req_qual
(
  input  wire       ref_clk,  // System clock
  input  wire       rst_n,    // Synchronous reset, active low
  input  wire [7:1] lvl_in,   // Raw request per level
  output wire [7:1] lvl_ok    // Qualified request per level
);

  // ==========================================================
  // Per level sampling
  genvar g;
  generate
    for (g = 1; g <= 7; g = g + 1)
    begin : g_lvl
      reg s1_r;
      reg s2_r;
      // Two consecutive falling-edge samples filter a one-period glitch
      always @(negedge ref_clk)
      begin
        if (!rst_n)
        begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end
        else
        begin
          s1_r <= lvl_in[g];
          s2_r <= s1_r;
        end
      end
      assign lvl_ok[g] = s1_r & s2_r;
    end
  endgenerate

endmodule // iaa_req_qual

// File: iaa_ctrl.v
// Interrupt recognition, acknowledge cycle, arbitration and vectoring.
// Assumes synchronous request inputs and an Avalon-MM master for registers.
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "iaa_consts.vh"

module iaa_ctrl
#(
  parameter NMOD     = 3,               // Internal requesting modules
  parameter BMON_CYC = `IAA_BMON_CYC    // Bus monitor limit in cycles
)
(
  input  wire                ref_clk,          // System clock
  input  wire                rst_n,            // Synchronous reset, active low
  input  wire [1:0]          avs_address,      // Register word index
  input  wire                avs_read,         // Read strobe
  input  wire                avs_write,        // Write strobe
  input  wire [31:0]         avs_writedata,    // Write data
  output reg  [31:0]         avs_readdata,     // Read data
  output wire                avs_waitrequest,  // Stall
  input  wire [7:1]          irq_n,            // External requests, active low
  input  wire                pit_req,          // Timer request
  input  wire [2:0]          pit_lvl,          // Timer request level
  input  wire [7:0]          pit_vec,          // Timer vector
  input  wire [NMOD-1:0]     mod_req,          // Module requests
  input  wire [3*NMOD-1:0]   mod_lvl,          // Module levels
  input  wire [8*NMOD-1:0]   mod_vec,          // Module vectors
  input  wire [NMOD-1:0]     mod_avec,         // Module wants autovector
  input  wire                at_boundary,      // Instruction boundary reached
  output wire                stack_req,        // Save processor state
  input  wire                stack_done,       // State saved
  output reg  [2:0]          fc,               // Function code
  output reg  [23:0]         addr,             // Address bus
  output wire                ebi_cycle,        // Ack passed to external bus
  input  wire [7:0]          ebi_data,         // External vector
  input  wire                ebi_term,         // External termination
  input  wire                avec_n,           // Autovector request, active low
  output reg                 bus_err,          // Spurious bus error pulse
  output reg  [7:0]          vec_num,          // Vector number
  output reg  [23:0]         vec_addr,         // Vector address
  output wire                vec_fetch,        // Fetch vector table entry
  input  wire [15:0]         fetch_data,       // Fetched handler address
  input  wire                fetch_done,       // Fetch complete
  output reg  [15:0]         pc,               // Program counter
  output reg                 handler_go        // Handler entry pulse
);

  localparam S_IDLE  = 3'h0;
  localparam S_STACK = 3'h1;
  localparam S_ACK   = 3'h2;
  localparam S_ARB   = 3'h3;
  localparam S_RES   = 3'h4;
  localparam S_EXT   = 3'h5;
  localparam S_FETCH = 3'h6;
  localparam NC      = NMOD + 1;   // Contenders, index 0 is the unit
  localparam AW      = `IAA_ARB_W * NC;

  reg  [2:0]    state_r;
  reg  [2:0]    mask_r;
  reg  [2:0]    mask_q_r;
  reg  [3:0]    bank_r;
  reg  [AW-1:0] arb_r;
  reg  [2:0]    lvl_r;
  reg  [NC-1:0] cont_r;
  reg  [1:0]    bit_r;
  reg           nmi_r;
  reg           nmi_q_r;
  reg           spur_r;
  reg           done_r;
  reg  [15:0]   tmo_r;
  reg  [7:1]    pend_raw;
  reg  [2:0]    hit_lvl;
  reg           hit;
  reg  [NC-1:0] join_nxt;
  reg           wire_or;
  reg  [NC-1:0] win;
  reg  [3:0]    win_arb;
  reg  [7:0]    win_vec;
  reg           win_avec;
  wire [7:1]    pend;
  wire [7:0]    avec_num;
  integer       i;

  // ==========================================================
  // Bus slave: one wait cycle, write lands on the answering edge
  assign avs_waitrequest = (avs_read | avs_write) & ~done_r;
  wire acc = done_r & (avs_read | avs_write);
  wire wr  = acc & avs_write;

  // ==========================================================
  // Merge internal, timer and external requests per level
  always @*
  begin
    pend_raw = ~irq_n;
    for (i = 0; i < NMOD; i = i + 1)
      if (mod_req[i] && mod_lvl[3*i +: 3] != 3'h0)
        pend_raw[mod_lvl[3*i +: 3]] = 1'b1;
    if (pit_req && pit_lvl != 3'h0)
      pend_raw[pit_lvl] = 1'b1;
  end

  iaa_req_qual u_qual
  (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .lvl_in  (pend_raw),
    .lvl_ok  (pend)
  );

  // ==========================================================
  // Recognition: highest level above mask; level seven by event
  always @*
  begin
    hit     = 1'b0;
    hit_lvl = 3'h0;
    for (i = 1; i < 7; i = i + 1)
      if (pend[i] && i > mask_r)
      begin
        hit     = 1'b1;
        hit_lvl = i[2:0];
      end
    if (nmi_r)
    begin
      hit     = 1'b1;
      hit_lvl = `IAA_LVL_NMI;
    end
  end

  // ==========================================================
  // Contender set at the acknowledged level
  always @*
  begin
    join_nxt = {NC{1'b0}};
    // External and timer requests both count as the unit
    join_nxt[0] = (~irq_n[7:1] != 7'h00 && ~irq_n[lvl_r] == 1'b1)
                | (pit_req && pit_lvl == lvl_r);
    for (i = 0; i < NMOD; i = i + 1)
      join_nxt[i+1] = mod_req[i] && mod_lvl[3*i +: 3] == lvl_r;
  end

  // ==========================================================
  // Wired-OR of the bit under contention
  always @*
  begin
    wire_or = 1'b0;
    for (i = 0; i < NC; i = i + 1)
      if (cont_r[i] && arb_r[`IAA_ARB_W*i + bit_r])
        wire_or = 1'b1;
  end

  // ==========================================================
  // Winner pick; lowest index breaks an illegal tie
  always @*
  begin
    win      = {NC{1'b0}};
    win_arb  = `IAA_ARB_ZERO;
    win_vec  = `IAA_SPUR_VEC;
    win_avec = 1'b0;
    for (i = NC - 1; i >= 0; i = i - 1)
      if (cont_r[i])
      begin
        win     = {NC{1'b0}};
        win[i]  = 1'b1;
        win_arb = arb_r[`IAA_ARB_W*i +: `IAA_ARB_W];
      end
    for (i = 0; i < NMOD; i = i + 1)
      if (win[i+1])
      begin
        win_vec  = mod_vec[8*i +: 8];
        win_avec = mod_avec[i];
      end
  end

  assign avec_num  = `IAA_AVEC_BASE + {5'h00, lvl_r};
  assign stack_req = (state_r == S_STACK);
  assign ebi_cycle = (state_r == S_EXT);
  assign vec_fetch = (state_r == S_FETCH);

  // ==========================================================
  // Sequencer, registers and level-seven event tracking
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_r      <= S_IDLE;
      mask_r       <= `IAA_MASK_RST;
      mask_q_r     <= `IAA_MASK_RST;
      bank_r       <= `IAA_BANK_RST;
      arb_r        <= {{(AW-`IAA_ARB_W){1'b0}}, `IAA_ARB_SIM_RST};
      lvl_r        <= 3'h0;
      cont_r       <= {NC{1'b0}};
      bit_r        <= `IAA_ARB_MSB;
      nmi_r        <= 1'b0;
      nmi_q_r      <= 1'b0;
      spur_r       <= 1'b0;
      done_r       <= 1'b0;
      tmo_r        <= 16'h0000;
      fc           <= 3'h0;
      addr         <= 24'h000000;
      bus_err      <= 1'b0;
      vec_num      <= 8'h00;
      vec_addr     <= 24'h000000;
      pc           <= 16'h0000;
      handler_go   <= 1'b0;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      done_r     <= (avs_read | avs_write) & ~done_r;
      bus_err    <= 1'b0;
      handler_go <= 1'b0;
      nmi_q_r    <= pend[7];
      mask_q_r   <= mask_r;
      // New assertion or mask drop from all ones re-arms level seven
      if ((pend[7] && !nmi_q_r) ||
          (pend[7] && mask_q_r == `IAA_LVL_NMI && mask_r != `IAA_LVL_NMI))
        nmi_r <= 1'b1;
      else if (state_r == S_ACK && lvl_r == `IAA_LVL_NMI)
        nmi_r <= 1'b0;

      // Register writes; sequencer updates below take precedence
      if (wr && avs_address == `IAA_REG_CCR)
      begin
        mask_r <= avs_writedata[`IAA_MASK_HI:`IAA_MASK_LO];
        bank_r <= avs_writedata[`IAA_BANK_HI:`IAA_BANK_LO];
      end
      else if (wr && avs_address == `IAA_REG_ARB)
        arb_r <= avs_writedata[AW-1:0];

      // Read mux; all four words are mapped, unused bits read zero
      if (avs_address == `IAA_REG_CCR)
        avs_readdata <= {24'h000000, mask_r, 1'b0, bank_r};
      else if (avs_address == `IAA_REG_ARB)
        avs_readdata <= {{(32-AW){1'b0}}, arb_r};
      else if (avs_address == `IAA_REG_STAT)
        avs_readdata <= {15'h0000, spur_r, vec_num, 2'h0, lvl_r, state_r};
      else
        avs_readdata <= {16'h0000, pc};

      case (state_r)
        S_IDLE:
        begin
          if (at_boundary && hit)
          begin
            lvl_r   <= hit_lvl;
            state_r <= S_STACK;
          end
        end
        S_STACK:
        begin
          if (stack_done)
          begin
            bank_r  <= `IAA_BANK_RST;
            fc      <= `IAA_FC_CPU;
            addr    <= {`IAA_ADDR_ONES, lvl_r, `IAA_ADDR_LSB};
            state_r <= S_ACK;
          end
        end
        S_ACK:
        begin
          mask_r  <= addr[3:1];
          cont_r  <= join_nxt;
          bit_r   <= `IAA_ARB_MSB;
          state_r <= S_ARB;
        end
        S_ARB:
        begin
          // Withdraw on a dominant one that this contender did not drive
          for (i = 0; i < NC; i = i + 1)
            if (wire_or && !arb_r[`IAA_ARB_W*i + bit_r])
              cont_r[i] <= 1'b0;
          bit_r <= bit_r - 2'h1;
          if (bit_r == 2'h0)
            state_r <= S_RES;
        end
        S_RES:
        begin
          spur_r <= 1'b0;
          tmo_r  <= 16'h0000;
          if (cont_r == {NC{1'b0}})
          begin
            bus_err <= 1'b1;
            spur_r  <= 1'b1;
            vec_num <= `IAA_SPUR_VEC;
            state_r <= S_FETCH;
          end
          else if (win_arb == `IAA_ARB_ZERO)
          begin
            spur_r  <= 1'b1;
            vec_num <= `IAA_SPUR_VEC;
            state_r <= S_FETCH;
          end
          else if (win[0] && pit_req && pit_lvl == lvl_r)
          begin
            vec_num <= pit_vec;
            state_r <= S_FETCH;
          end
          else if (win[0])
            state_r <= S_EXT;
          else
          begin
            vec_num <= win_avec ? avec_num : win_vec;
            state_r <= S_FETCH;
          end
        end
        S_EXT:
        begin
          tmo_r <= tmo_r + 16'h0001;
          if (!avec_n)
          begin
            vec_num <= avec_num;
            state_r <= S_FETCH;
          end
          else if (ebi_term)
          begin
            vec_num <= ebi_data;
            state_r <= S_FETCH;
          end
          else if (tmo_r == BMON_CYC[15:0] - 16'h0001)
          begin
            bus_err <= 1'b1;
            spur_r  <= 1'b1;
            vec_num <= `IAA_SPUR_VEC;
            state_r <= S_FETCH;
          end
        end
        S_FETCH:
        begin
          fc       <= 3'h0;
          addr     <= 24'h000000;
          vec_addr <= {16'h0000, vec_num} << `IAA_VADDR_SHIFT;
          if (fetch_done)
          begin
            pc         <= fetch_data;
            handler_go <= 1'b1;
            state_r    <= S_IDLE;
          end
        end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end

endmodule // iaa_ctrl

// File: iaa_ctrl_monitor.sv
// Checker for the acknowledge block, bound to every iaa_ctrl.
// Assumes iaa_ctrl port names and a single clock domain.
`timescale 1ns/1ps
`include "iaa_consts.vh"
module iaa_ctrl_monitor
#(
  parameter NMOD     = 3,  // Internal modules
  parameter BMON_CYC = 8   // Bus monitor limit
)
(
  input wire        ref_clk,          // Clock
  input wire        rst_n,            // Reset, active low
  input wire        avs_read,         // Read strobe
  input wire        avs_write,        // Write strobe
  input wire        avs_waitrequest,  // Stall
  input wire        stack_req,        // Save request
  input wire        stack_done,       // Saved
  input wire [2:0]  fc,               // Function code
  input wire [23:0] addr,             // Address bus
  input wire        ebi_cycle,        // External acknowledge
  input wire        ebi_term,         // External termination
  input wire        avec_n,           // Autovector, active low
  input wire        bus_err,          // Bus error pulse
  input wire [7:0]  vec_num,          // Vector number
  input wire [23:0] vec_addr,         // Vector address
  input wire        vec_fetch,        // Table fetch
  input wire        fetch_done,       // Fetch complete
  input wire [15:0] fetch_data,       // Handler address
  input wire [15:0] pc,               // Program counter
  input wire        handler_go        // Handler entry
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ====================
  // Helper: length of the external acknowledge, so a stuck cycle shows
  reg [7:0] bcnt_r;
  always @(posedge ref_clk)
    if (!rst_n) bcnt_r <= 8'h0;
    else bcnt_r <= ebi_cycle ? bcnt_r + 8'h1 : 8'h0;
  // ====================
  // Sequences and properties
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence s_load;
    ##1 (handler_go && pc == $past(fetch_data));
  endsequence
  property p_wait;
    $rose(avs_read | avs_write) |-> s_one_wait;
  endproperty
  property p_addr;
    fc == `IAA_FC_CPU |-> addr[23:4] == `IAA_ADDR_ONES && addr[0];
  endproperty
  property p_stack_hold;
    stack_req && !stack_done |=> stack_req;
  endproperty
  property p_ack_start;
    stack_req && stack_done |=> fc == `IAA_FC_CPU;
  endproperty
  property p_ebi;
    ebi_cycle |-> fc == `IAA_FC_CPU && addr[3:1] != 3'h0;
  endproperty
  property p_term;
    ebi_cycle && (ebi_term || !avec_n) |=> !ebi_cycle;
  endproperty
  property p_bmon;
    bcnt_r <= BMON_CYC + 2;
  endproperty
  property p_err_vec;
    bus_err |-> ##[0:2] vec_num == `IAA_SPUR_VEC;
  endproperty
  property p_fetch;
    vec_fetch && fetch_done |-> s_load;
  endproperty
  property p_vaddr;
    handler_go |-> vec_addr == {15'h0, vec_num, 1'b0};
  endproperty
  a_wait: assert property (p_wait) else $error("wait state count wrong");
  a_addr: assert property (p_addr) else $error("ack address wrong");
  a_stack_hold: assert property (p_stack_hold) else $error("save dropped");
  a_ack_start: assert property (p_ack_start) else $error("no ack after save");
  a_ebi: assert property (p_ebi) else $error("external cycle outside ack");
  a_term: assert property (p_term) else $error("external cycle not ended");
  a_bmon: assert property (p_bmon) else $error("bus monitor missed");
  a_err_vec: assert property (p_err_vec) else $error("no spurious vector");
  a_fetch: assert property (p_fetch) else $error("counter not loaded");
  a_vaddr: assert property (p_vaddr) else $error("vector address wrong");
endmodule // iaa_ctrl_monitor

bind iaa_ctrl iaa_ctrl_monitor #(.NMOD(NMOD), .BMON_CYC(BMON_CYC)) iaa_ctrl_monitor_i (.*);

// File: iaa_far_model.sv
// Far-side model: state save, external acknowledge answer, table fetch.
// Assumes each request is a level held until its answer is taken.
`timescale 1ns/1ps
module iaa_far_model
(
  input  wire        ref_clk,     // Clock
  input  wire        rst_n,       // Reset, active low
  input  wire [1:0]  ext_mode,    // 0 vector, 1 autovector, 2 silent
  input  wire        stack_req,   // Save request
  input  wire        ebi_cycle,   // External acknowledge
  input  wire        vec_fetch,   // Table fetch
  input  wire [23:0] vec_addr,    // Table address
  output reg         stack_done,  // Saved
  output reg         ebi_term,    // Termination
  output reg         avec_n,      // Autovector, active low
  output reg  [7:0]  ebi_data,    // Vector
  output reg         fetch_done,  // Fetch complete
  output reg  [15:0] fetch_data   // Handler address
);
  wire [2:0] act_w = {stack_req, ebi_cycle, vec_fetch};
  reg  [2:0] act_r;
  reg  [1:0] dly_r;
  wire       go_w  = (dly_r == 2'h1);
  // ====================
  // Answer late, so a design that assumes an instant reply fails;
  // released data lines toggle rather than hold the last value
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      act_r      <= 3'h0;
      dly_r      <= 2'h3;
      stack_done <= 1'b0;
      ebi_term   <= 1'b0;
      avec_n     <= 1'b1;
      ebi_data   <= 8'h00;
      fetch_done <= 1'b0;
      fetch_data <= 16'h0000;
    end
    else
    begin
      act_r      <= act_w;
      dly_r      <= (act_w != act_r) ? 2'h0 : ((dly_r == 2'h3) ? 2'h3 : dly_r + 2'h1);
      stack_done <= stack_req & go_w;
      ebi_term   <= ebi_cycle & go_w & (ext_mode == 2'h0);
      avec_n     <= ~(ebi_cycle & go_w & (ext_mode == 2'h1));
      ebi_data   <= (ebi_cycle & go_w) ? 8'h77 : ~ebi_data;
      fetch_done <= vec_fetch & go_w;
      fetch_data <= vec_fetch ? {8'hA5, vec_addr[8:1]} : ~fetch_data;
    end
  end
endmodule // iaa_far_model

// File: iaa_ctrl_tb_top.sv
// Testbench: register access, then acknowledge scenarios by table.
// Assumes iaa_ctrl with three modules and a short bus monitor.
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    total_checks = total_checks + 1; \
    if ((a) !== (e)) \
    begin \
      failures = failures + 1; \
      $display("ERROR %0t: got %h want %h", $time, a, e); \
    end \
  end
module iaa_ctrl_tb_top;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [1:0]  avs_address = 2'h0;
  reg         avs_read = 1'b0;
  reg         avs_write = 1'b0;
  reg  [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest;
  reg  [7:1]  irq_n = 7'h7F;
  reg         pit_req = 1'b0;
  reg  [2:0]  pit_lvl = 3'h4;
  reg  [7:0]  pit_vec = 8'h50;
  reg  [2:0]  mod_req = 3'h0;
  reg  [8:0]  mod_lvl = 9'h0;
  reg  [23:0] mod_vec = 24'h424140;
  reg  [2:0]  mod_avec = 3'h0;
  reg         at_boundary = 1'b0;
  reg  [1:0]  ext_mode = 2'h0;
  wire        stack_req, stack_done, ebi_cycle, ebi_term, avec_n, bus_err;
  wire        vec_fetch, fetch_done, handler_go;
  wire [2:0]  fc;
  wire [23:0] addr, vec_addr;
  wire [7:0]  ebi_data, vec_num;
  wire [15:0] fetch_data, pc;
  integer     failures = 0;
  integer     total_checks = 0;
  integer     n;
  reg  [31:0] q;
  reg         err_seen, ebi_seen;

  always #10 ref_clk = ~ref_clk;

  iaa_ctrl #(.NMOD(3), .BMON_CYC(8)) iaa_ctrl_i (.*);
  iaa_far_model iaa_far_model_i (.*);

  // ====================
  // Verdict, also reached by any wait that runs out
  task test_done;
  begin
    $display("Checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask

  task wt(input ok);
  begin
    if (!ok)
    begin
      failures = failures + 1;
      $display("ERROR %0t: wait ran out", $time);
      test_done;
    end
  end
  endtask

  // ====================
  // Avalon access: hold until waitrequest is seen low
  task acc(input w, input [1:0] a, input [31:0] d);
  begin
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    // Waitrequest and read data are taken as they stand at the rising edge
    do
    begin
      @(posedge ref_clk);
      n = n + 1;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    wt(avs_waitrequest === 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  end
  endtask

  // ====================
  // One acknowledge: raise requests, follow to the handler, check all
  task go(input [2:0] mr, input [8:0] ml, input [2:0] ma, input [7:1] ir,
          input pr, input [1:0] md, input [2:0] lv, input [7:0] vc,
          input er, input eb);
  begin
    @(posedge ref_clk);
    mod_req <= mr;
    mod_lvl <= ml;
    mod_avec <= ma;
    irq_n <= ~ir;
    pit_req <= pr;
    ext_mode <= md;
    err_seen = 1'b0;
    ebi_seen = 1'b0;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n = n + 1;
    end while (fc !== 3'h7 && n < 300);
    wt(fc === 3'h7);
    `CHK(addr, {20'hFFFFF, lv, 1'b1})
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n = n + 1;
      err_seen = err_seen | (bus_err === 1'b1);
      ebi_seen = ebi_seen | (ebi_cycle === 1'b1);
    end while (handler_go !== 1'b1 && n < 300);
    wt(handler_go === 1'b1);
    `CHK(vec_num, vc)
    `CHK(vec_addr, {15'h0, vc, 1'b0})
    `CHK(pc, {8'hA5, vc})
    `CHK(err_seen, er)
    `CHK(ebi_seen, eb)
    @(posedge ref_clk);
    mod_req <= 3'h0;
    irq_n <= 7'h7F;
    pit_req <= 1'b0;
    acc(1'b0, 2'h0, 32'h0);
    `CHK(q[7:5], lv)
    `CHK(q[3:0], 4'h0)
    // Open the mask and set the bank again so the next clear is visible
    acc(1'b1, 2'h0, 32'h0000000F);
  end
  endtask

  // ====================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    at_boundary <= 1'b1;
    acc(1'b0, 2'h0, 32'h0);
    `CHK(q, 32'h000000E0)
    acc(1'b0, 2'h1, 32'h0);
    `CHK(q, 32'h0000000F)
    acc(1'b1, 2'h1, 32'h00000214);
    acc(1'b0, 2'h1, 32'h0);
    `CHK(q, 32'h00000214)
    // Reset mask hides levels one to six; open it and load a bank value
    acc(1'b1, 2'h0, 32'h0000000F);
    acc(1'b0, 2'h0, 32'h0);
    `CHK(q, 32'h0000000F)
    go(3'h7, 9'h09B, 3'h0, 7'h00, 1'b0, 2'h0, 3'h3, 8'h41, 1'b0, 1'b0);
    go(3'h1, 9'h002, 3'h1, 7'h00, 1'b0, 2'h0, 3'h2, 8'h1A, 1'b0, 1'b0);
    go(3'h4, 9'h180, 3'h0, 7'h00, 1'b0, 2'h0, 3'h6, 8'h18, 1'b0, 1'b0);
    go(3'h0, 9'h000, 3'h0, 7'h10, 1'b0, 2'h0, 3'h5, 8'h77, 1'b0, 1'b1);
    go(3'h0, 9'h000, 3'h0, 7'h10, 1'b0, 2'h1, 3'h5, 8'h1D, 1'b0, 1'b1);
    go(3'h0, 9'h000, 3'h0, 7'h10, 1'b0, 2'h2, 3'h5, 8'h18, 1'b1, 1'b1);
    go(3'h0, 9'h000, 3'h0, 7'h08, 1'b1, 2'h0, 3'h4, 8'h50, 1'b0, 1'b0);
    go(3'h2, 9'h020, 3'h0, 7'h08, 1'b0, 2'h0, 3'h4, 8'h77, 1'b0, 1'b1);
    go(3'h3, 9'h031, 3'h0, 7'h00, 1'b0, 2'h0, 3'h6, 8'h41, 1'b0, 1'b0);
    // A level at the mask must stay unseen, one above it is taken
    acc(1'b1, 2'h0, 32'h00000080);
    @(posedge ref_clk);
    mod_req <= 3'h1;
    mod_lvl <= 9'h004;
    err_seen = 1'b0;
    repeat (30)
    begin
      @(negedge ref_clk);
      err_seen = err_seen | (stack_req === 1'b1);
    end
    `CHK(err_seen, 1'b0)
    go(3'h1, 9'h005, 3'h0, 7'h00, 1'b0, 2'h0, 3'h5, 8'h40, 1'b0, 1'b0);
    acc(1'b1, 2'h0, 32'h000000E0);
    go(3'h1, 9'h007, 3'h0, 7'h00, 1'b0, 2'h0, 3'h7, 8'h40, 1'b0, 1'b0);
    test_done;
  end
endmodule // iaa_ctrl_tb_top
